// [hw/typec_src_pkg.sv]
/*
 * shared constants for the type-c source port control block:
 * register map, field positions, reset values and timing counts.
 * assumes a 200 mhz aclk and a 32-bit axi4-lite register bus.
 */
package typec_src_pkg;

  // register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] irq_status_off = 8'h08;
  localparam logic [7:0] irq_mask_off = 8'h0c;
  localparam logic [7:0] cc_level_off = 8'h10;

  // control register fields
  localparam int ctrl_enable_bit = 0;
  localparam int ctrl_usb3_bit = 1;
  localparam int ctrl_discharge_en_bit = 2;
  localparam logic [31:0] ctrl_reset = 32'h0000_0005;

  // status register fields
  localparam int st_attach_bit = 0;
  localparam int st_orient_bit = 1;
  localparam int st_audio_bit = 2;
  localparam int st_debug_bit = 3;
  localparam int st_fault_bit = 4;
  localparam int st_heavy_bit = 5;
  localparam int st_vbus_bit = 6;
  localparam int st_vconn_bit = 7;
  localparam int st_limit_bit = 8;

  // event bits, shared by irq status and mask
  localparam int ev_attach_bit = 0;
  localparam int ev_detach_bit = 1;
  localparam int ev_fault_bit = 2;
  localparam int ev_heavy_bit = 3;
  localparam int ev_count = 4;
  localparam logic [ev_count-1:0] irq_mask_reset = 4'h0;

  // cc line levels as seen by the comparators
  typedef enum logic [1:0] {
    cc_open,
    cc_rd,
    cc_ra
  } cc_level_t;

  // advertised current, driven on both cc lines
  typedef enum logic [1:0] {
    adv_default,
    adv_1p5a,
    adv_3a
  } adv_level_t;

  // port states
  typedef enum logic [2:0] {
    st_off,
    st_unattached,
    st_debounce,
    st_sink,
    st_audio,
    st_debug,
    st_discharge
  } port_state_t;

  // timing
  localparam int clk_mhz = 200;
  localparam int debounce_us = 150;
  localparam int debounce_cycles = debounce_us * clk_mhz;
  localparam int discharge_us = 50;
  localparam int discharge_cycles = discharge_us * clk_mhz;
  localparam int cnt_width = 16;

endpackage

// [hw/pin_sync.sv]
/*
 * three-stage synchroniser for one pin input with a change qualifier.
 * assumes the input is asynchronous to aclk; the output only moves
 * when the second and third stage agree.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter logic reset_value = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pin and clean level
  input wire logic pin,
  output logic level
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= reset_value;
      s2_q <= reset_value;
      s3_q <= reset_value;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q <= reset_value;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  assign level = level_q;

endmodule
`default_nettype wire

// [hw/typec_src_ctrl.sv]
/*
 * type-c downstream port control: cc attach and detach detection,
 * orientation, accessory identification, current advertisement,
 * vbus and vconn switch control, open-drain flags, axi4-lite registers.
 * assumes cc comparator levels, switch limit and thermal events come
 * from analog logic outside, asynchronous to aclk.
 */
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
// Functional notes
// - watch both cc lines for attach/detach
// - sink attached: close charging supply switch
// - advertise selected current on connected cc (code drives it on both cc lines whenever on)
// - marked cable: vconn onto other cc
// - attach flag active when sink identified
// - orientation flag when second cc connects
// - audio flag on audio accessory pattern
// - debug flag on debug accessory pattern
// - fault low on current limit or overtemperature
// - heavy load above 1.95a at 3a
// - low type-c select picks default usb level
// - high current select 1.5a/3a, type-c only
// - two switch limits, 1.7a and 3.4a
// - enable turns whole device on/off (code keeps switch_current_limit following the selects when off)
`timescale 1ns/1ps
`default_nettype none
module typec_src_ctrl
  import typec_src_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // control pins
  input wire logic enable_pin,
  input wire logic type_c_current_select,
  input wire logic high_current_select,
  // cc comparator levels, 00 open, 01 rd, 10 ra
  input wire logic [1:0] cc1_level,
  input wire logic [1:0] cc2_level,
  // analog switch events
  input wire logic limit_active,
  input wire logic over_temp,
  input wire logic load_above_1p95a,
  // switch and cc drive
  output logic vbus_switch_on,
  output logic vbus_discharge_on,
  output logic vconn_cc1_on,
  output logic vconn_cc2_on,
  output logic switch_current_limit,
  output logic [1:0] cc1_advertise,
  output logic [1:0] cc2_advertise,
  // open-drain flags, enable high pulls the pin low
  output logic attach_flag_oe,
  output logic orientation_flag_oe,
  output logic audio_flag_oe,
  output logic debug_flag_oe,
  output logic fault_flag_oe,
  output logic heavy_load_flag_oe,
  // interrupt
  output logic irq
);

  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  // synchronised pins
  localparam int n_pins = 11;
  logic [n_pins-1:0] pin_raw;
  logic [n_pins-1:0] pin_lvl;
  assign pin_raw = {enable_pin, type_c_current_select, high_current_select,
                    cc1_level, cc2_level, limit_active, over_temp,
                    load_above_1p95a, 1'b0};

  genvar gi;
  generate
    for (gi = 0; gi < n_pins; gi++) begin : g_sync
      pin_sync #(.reset_value(1'b0)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(pin_raw[gi]),
        .level(pin_lvl[gi])
      );
    end
  endgenerate

  logic en_s, tc_sel_s, hi_sel_s, lim_s, ot_s, load_s;
  cc_level_t cc1_s, cc2_s;
  assign en_s = pin_lvl[10];
  assign tc_sel_s = pin_lvl[9];
  assign hi_sel_s = pin_lvl[8];
  assign cc1_s = cc_level_t'(pin_lvl[7:6]);
  assign cc2_s = cc_level_t'(pin_lvl[5:4]);
  assign lim_s = pin_lvl[3];
  assign ot_s = pin_lvl[2];
  assign load_s = pin_lvl[1];

  // registers
  logic [2:0] ctrl_q;
  logic [ev_count-1:0] irq_status_q;
  logic [ev_count-1:0] irq_mask_q;
  logic device_on;
  assign device_on = en_s && ctrl_q[ctrl_enable_bit];

  // cc pattern classification
  port_state_t state_q;
  port_state_t pattern;
  logic orient_d;
  logic marked_d;
  always_comb begin
    pattern = st_unattached;
    orient_d = 1'b0;
    marked_d = 1'b0;
    if (cc1_s == cc_rd && cc2_s == cc_rd) begin
      pattern = st_debug;
    end else if (cc1_s == cc_ra && cc2_s == cc_ra) begin
      pattern = st_audio;
    end else if (cc1_s == cc_rd) begin
      pattern = st_sink;
      marked_d = (cc2_s == cc_ra);
    end else if (cc2_s == cc_rd) begin
      pattern = st_sink;
      orient_d = 1'b1;
      marked_d = (cc1_s == cc_ra);
    end
  end

  // debounce of a stable cc pattern
  logic [cnt_width-1:0] cnt_q;
  port_state_t cand_q;
  logic orient_q;
  logic marked_q;
  logic cnt_done;
  assign cnt_done = (cnt_q == cnt_width'(debounce_cycles - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= st_off;
      cand_q <= st_unattached;
      cnt_q <= '0;
      orient_q <= 1'b0;
      marked_q <= 1'b0;
    end else if (!device_on) begin
      state_q <= st_off;
      cnt_q <= '0;
    end else begin
      case (state_q)
        st_off: begin
          state_q <= st_unattached;
        end
        st_unattached: begin
          cnt_q <= '0;
          cand_q <= pattern;
          if (pattern != st_unattached) begin
            state_q <= st_debounce;
          end
        end
        st_debounce: begin
          if (pattern != cand_q) begin
            state_q <= st_unattached;
          end else if (cnt_done) begin
            state_q <= cand_q;
            orient_q <= orient_d;
            marked_q <= marked_d;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        st_sink, st_audio, st_debug: begin
          cnt_q <= '0;
          if (pattern != state_q) begin
            state_q <= st_discharge;
          end
        end
        st_discharge: begin
          if (cnt_q == cnt_width'(discharge_cycles - 1)) begin
            state_q <= st_unattached;
            orient_q <= 1'b0;
            marked_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= st_off;
        end
      endcase
    end
  end

  // current advertisement and switch limit
  adv_level_t adv;
  always_comb begin
    if (!tc_sel_s) begin
      adv = adv_default;
    end else if (hi_sel_s) begin
      adv = adv_3a;
    end else begin
      adv = adv_1p5a;
    end
  end

  logic sink_on;
  assign sink_on = (state_q == st_sink);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vbus_switch_on <= 1'b0;
      vbus_discharge_on <= 1'b0;
      vconn_cc1_on <= 1'b0;
      vconn_cc2_on <= 1'b0;
      switch_current_limit <= 1'b0;
      cc1_advertise <= 2'h0;
      cc2_advertise <= 2'h0;
    end else begin
      vbus_switch_on <= sink_on && !ot_s;
      vbus_discharge_on <= (state_q == st_discharge)
                           && ctrl_q[ctrl_discharge_en_bit];
      vconn_cc1_on <= sink_on && marked_q && orient_q;
      vconn_cc2_on <= sink_on && marked_q && !orient_q;
      switch_current_limit <= (adv == adv_3a);
      cc1_advertise <= device_on ? 2'(adv) : 2'h0;
      cc2_advertise <= device_on ? 2'(adv) : 2'h0;
    end
  end

  // open-drain flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      attach_flag_oe <= 1'b0;
      orientation_flag_oe <= 1'b0;
      audio_flag_oe <= 1'b0;
      debug_flag_oe <= 1'b0;
      fault_flag_oe <= 1'b0;
      heavy_load_flag_oe <= 1'b0;
    end else begin
      attach_flag_oe <= sink_on;
      orientation_flag_oe <= sink_on && orient_q;
      audio_flag_oe <= (state_q == st_audio);
      debug_flag_oe <= (state_q == st_debug);
      fault_flag_oe <= device_on && (lim_s || ot_s);
      heavy_load_flag_oe <= sink_on && (adv == adv_3a) && load_s;
    end
  end

  // event edges
  logic attach_prev_q, fault_prev_q, heavy_prev_q;
  logic [ev_count-1:0] ev;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      attach_prev_q <= 1'b0;
      fault_prev_q <= 1'b0;
      heavy_prev_q <= 1'b0;
    end else begin
      attach_prev_q <= attach_flag_oe;
      fault_prev_q <= fault_flag_oe;
      heavy_prev_q <= heavy_load_flag_oe;
    end
  end
  always_comb begin
    ev = '0;
    ev[ev_attach_bit] = attach_flag_oe && !attach_prev_q;
    ev[ev_detach_bit] = !attach_flag_oe && attach_prev_q;
    ev[ev_fault_bit] = fault_flag_oe && !fault_prev_q;
    ev[ev_heavy_bit] = heavy_load_flag_oe && !heavy_prev_q;
  end

  // axi4-lite write path
  logic aw_held_q, w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == ctrl_off || awaddr_q == irq_mask_off)
                       ? resp_okay : resp_slverr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= ctrl_reset[2:0];
      irq_mask_q <= irq_mask_reset;
    end else if (do_write && wstrb_q[0]) begin
      if (awaddr_q == ctrl_off) begin
        ctrl_q <= wdata_q[2:0];
      end
      if (awaddr_q == irq_mask_off) begin
        irq_mask_q <= wdata_q[ev_count-1:0];
      end
    end
  end

  // axi4-lite read path; reading irq status clears it, new events win
  logic rd_irq;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_irq = s_axi_arvalid && s_axi_arready
                  && (s_axi_araddr == irq_status_off);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= (rd_irq ? '0 : irq_status_q) | ev;
    end
  end

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0;
    status_word[st_attach_bit] = attach_flag_oe;
    status_word[st_orient_bit] = orientation_flag_oe;
    status_word[st_audio_bit] = audio_flag_oe;
    status_word[st_debug_bit] = debug_flag_oe;
    status_word[st_fault_bit] = fault_flag_oe;
    status_word[st_heavy_bit] = heavy_load_flag_oe;
    status_word[st_vbus_bit] = vbus_switch_on;
    status_word[st_vconn_bit] = vconn_cc1_on || vconn_cc2_on;
    status_word[st_limit_bit] = switch_current_limit;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= resp_okay;
      case (s_axi_araddr)
        ctrl_off: s_axi_rdata <= {29'h0, ctrl_q};
        status_off: s_axi_rdata <= status_word;
        irq_status_off: s_axi_rdata <= {28'h0, irq_status_q};
        irq_mask_off: s_axi_rdata <= {28'h0, irq_mask_q};
        cc_level_off: s_axi_rdata <= {28'h0, 2'(cc2_s), 2'(cc1_s)};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= resp_slverr;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  logic unused_bits;
  assign unused_bits = pin_lvl[0] ^ ctrl_q[ctrl_usb3_bit] ^ (|wstrb_q[3:1]);

endmodule
`default_nettype wire

// [tb/typec_src_monitor.sv]
/*
 * pin and bus-handshake assertions for typec_src_ctrl.
 * assumes the package is compiled first; bound into the design below.
 */
`timescale 1ns/1ps
`default_nettype none
module typec_src_monitor
  import typec_src_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus answers
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // switch and cc drive
  input wire logic vbus_switch_on,
  input wire logic vbus_discharge_on,
  input wire logic vconn_cc1_on,
  input wire logic vconn_cc2_on,
  input wire logic switch_current_limit,
  input wire logic [1:0] cc1_advertise,
  input wire logic [1:0] cc2_advertise,
  // flags
  input wire logic attach_flag_oe,
  input wire logic orientation_flag_oe,
  input wire logic audio_flag_oe,
  input wire logic debug_flag_oe,
  input wire logic heavy_load_flag_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_vbus_attach:
    assert property (vbus_switch_on |-> attach_flag_oe)
    else $error("vbus on without attach");
  chk_limit_at_3a:
    assert property ((cc1_advertise == adv_3a || cc2_advertise == adv_3a)
      |-> switch_current_limit) else $error("3a advert with low limit");
  chk_limit_low:
    assert property (cc1_advertise == adv_1p5a |-> !switch_current_limit)
    else $error("high limit at 1.5a advert");
  chk_orient_vconn:
    assert property (orientation_flag_oe |-> !vconn_cc2_on)
    else $error("vconn on the sink side");
  chk_vconn_one_side:
    assert property ((vconn_cc1_on || vconn_cc2_on) |-> attach_flag_oe
      && !(vconn_cc1_on && vconn_cc2_on)) else $error("vconn misplaced");
  chk_audio_alone:
    assert property (audio_flag_oe |-> !(attach_flag_oe || debug_flag_oe
      || vbus_switch_on)) else $error("audio with other state");
  chk_heavy_at_3a:
    assert property (heavy_load_flag_oe |-> switch_current_limit)
    else $error("heavy flag below 3a");
  chk_discharge_open:
    assert property (vbus_discharge_on |-> !vbus_switch_on && !attach_flag_oe)
    else $error("discharge with switch closed");
  chk_detach_release:
    assert property ($fell(attach_flag_oe) |-> !vbus_switch_on && !vconn_cc1_on
      && !vconn_cc2_on && !orientation_flag_oe && !heavy_load_flag_oe)
    else $error("outputs kept after detach");
  chk_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read answer dropped");

  cover property ($rose(attach_flag_oe));
  cover property ($rose(audio_flag_oe));
  cover property ($rose(vbus_discharge_on));
endmodule

bind typec_src_ctrl typec_src_monitor typec_src_monitor_i (.aclk, .aresetn,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .vbus_switch_on, .vbus_discharge_on, .vconn_cc1_on,
  .vconn_cc2_on, .switch_current_limit, .cc1_advertise, .cc2_advertise,
  .attach_flag_oe, .orientation_flag_oe, .audio_flag_oe, .debug_flag_oe,
  .heavy_load_flag_oe);
`default_nettype wire

// [tb/sink_model.sv]
/*
 * far-side model: sink, marked cable or accessory terminations on cc.
 * assumes kind and flip are driven right after a clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module sink_model
  import typec_src_pkg::*;
(
  // what is plugged in, and whether the plug is turned
  input wire logic [2:0] kind,
  input wire logic flip,
  // cc levels seen by the port
  output logic [1:0] cc1_level,
  output logic [1:0] cc2_level
);
  logic [1:0] a;
  logic [1:0] b;
  always_comb begin
    case (kind)
      3'h1: begin a = cc_rd; b = cc_open; end
      3'h2: begin a = cc_rd; b = cc_ra; end
      3'h3: begin a = cc_ra; b = cc_ra; end
      3'h4: begin a = cc_rd; b = cc_rd; end
      default: begin a = cc_open; b = cc_open; end
    endcase
  end
  assign cc1_level = flip ? b : a;
  assign cc2_level = flip ? a : b;
endmodule
`default_nettype wire

// [tb/testbench.sv]
/*
 * self-checking bench: axi4-lite tasks, attach, currents, detach, audio.
 * assumes the design, package, monitor and sink model compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  import typec_src_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, vbus_switch_on, vbus_discharge_on;
  logic [1:0] s_axi_bresp, s_axi_rresp, cc1_level, cc2_level;
  logic enable_pin = 1'h1, type_c_current_select = 1'h1;
  logic high_current_select = 1'h1, limit_active = 1'h0, over_temp = 1'h0;
  logic load_above_1p95a = 1'h0, flip = 1'h0;
  logic [2:0] kind = 3'h0;
  logic vconn_cc1_on, vconn_cc2_on, switch_current_limit, attach_flag_oe;
  logic [1:0] cc1_advertise, cc2_advertise;
  logic orientation_flag_oe, audio_flag_oe, debug_flag_oe, fault_flag_oe;
  logic heavy_load_flag_oe;
  logic host_attach_n;
  int checks = 0, n_errors = 0, cyc = 0, i;
  adv_level_t ea;

  typec_src_ctrl typec_src_ctrl_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .enable_pin,
    .type_c_current_select, .high_current_select, .cc1_level, .cc2_level,
    .limit_active, .over_temp, .load_above_1p95a, .vbus_switch_on,
    .vbus_discharge_on, .vconn_cc1_on, .vconn_cc2_on, .switch_current_limit,
    .cc1_advertise, .cc2_advertise, .attach_flag_oe, .orientation_flag_oe,
    .audio_flag_oe, .debug_flag_oe, .fault_flag_oe, .heavy_load_flag_oe,
    .irq);
  sink_model sink_model_i (.kind, .flip, .cc1_level, .cc2_level);
  assign host_attach_n = attach_flag_oe ? 1'h0 : 1'h1;

  initial forever #2.5 aclk = ~aclk;

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      results();
    end
  end

  task automatic wchk(input string nm, input logic [7:0] a,
                      input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h1;
    @(posedge aclk);
    `CHK(nm, er, s_axi_bresp)
    s_axi_bready <= 1'h0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h1;
    @(posedge aclk);
    `CHK(nm, ed, s_axi_rdata)
    `CHK(nm, er, s_axi_rresp)
    s_axi_rready <= 1'h0;
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rchk("ctrl reset", ctrl_off, ctrl_reset, 2'h0);
    rchk("mask reset", irq_mask_off, 32'(irq_mask_reset), 2'h0);
    rchk("unmapped", 8'h14, 32'h0, 2'h2);
    wchk("status write", status_off, 32'hff, 2'h2);
    wchk("mask write", irq_mask_off, 32'hf, 2'h0);
    rchk("mask read", irq_mask_off, 32'hf, 2'h0);
    $display("test registers done");
    kind <= 3'h2;
    flip <= 1'h1;
    for (i = 0; i < 32000 && attach_flag_oe !== 1'h1; i++) @(posedge aclk);
    repeat (2) @(posedge aclk);
    `CHK("vbus", 1'h1, vbus_switch_on)
    `CHK("attach", 1'h1, attach_flag_oe)
    `CHK("host attach pin", 1'h0, host_attach_n)
    `CHK("orient", 1'h1, orientation_flag_oe)
    `CHK("vconn cc1", 1'h1, vconn_cc1_on)
    `CHK("vconn cc2", 1'h0, vconn_cc2_on)
    `CHK("irq attach", 1'h1, irq)
    rchk("status", status_off, 32'h1 << st_attach_bit | 32'h1 << st_orient_bit
      | 32'h1 << st_vbus_bit | 32'h1 << st_vconn_bit
      | 32'h1 << st_limit_bit, 2'h0);
    rchk("cc levels", cc_level_off, 32'h6, 2'h0);
    rchk("irq status", irq_status_off, 32'h1 << ev_attach_bit, 2'h0);
    @(posedge aclk);
    `CHK("irq cleared", 1'h0, irq)
    for (i = 0; i < 4; i++) begin
      type_c_current_select <= i[1];
      high_current_select <= i[0];
      repeat (8) @(posedge aclk);
      ea = i[1] ? (i[0] ? adv_3a : adv_1p5a) : adv_default;
      `CHK("advertise", ea, cc2_advertise)
      `CHK("limit", i[1] & i[0], switch_current_limit)
    end
    load_above_1p95a <= 1'h1;
    repeat (8) @(posedge aclk);
    `CHK("heavy", 1'h1, heavy_load_flag_oe)
    high_current_select <= 1'h0;
    repeat (8) @(posedge aclk);
    `CHK("heavy at 1.5a", 1'h0, heavy_load_flag_oe)
    high_current_select <= 1'h1;
    load_above_1p95a <= 1'h0;
    limit_active <= 1'h1;
    repeat (8) @(posedge aclk);
    `CHK("fault", 1'h1, fault_flag_oe)
    limit_active <= 1'h0;
    repeat (8) @(posedge aclk);
    `CHK("fault gone", 1'h0, fault_flag_oe)
    rchk("irq events", irq_status_off, 32'h1 << ev_fault_bit
      | 32'h1 << ev_heavy_bit, 2'h0);
    $display("test attach done");
    kind <= 3'h0;
    repeat (8) @(posedge aclk);
    `CHK("detach vbus", 1'h0, vbus_switch_on)
    `CHK("detach attach", 1'h0, attach_flag_oe)
    `CHK("discharge", 1'h1, vbus_discharge_on)
    `CHK("detach vconn", 1'h0, vconn_cc1_on)
    `CHK("detach orient", 1'h0, orientation_flag_oe)
    wchk("mask off", irq_mask_off, 32'h0, 2'h0);
    `CHK("irq masked", 1'h0, irq)
    wchk("mask on", irq_mask_off, 32'hf, 2'h0);
    `CHK("irq detach", 1'h1, irq)
    rchk("irq detach", irq_status_off, 32'h1 << ev_detach_bit, 2'h0);
    for (i = 0; i < 11000 && vbus_discharge_on !== 1'h0; i++) @(posedge aclk);
    `CHK("discharge end", 1'h0, vbus_discharge_on)
    `CHK("host 5v cut", 1'h1, host_attach_n)
    $display("test detach done");
    kind <= 3'h3;
    for (i = 0; i < 32000 && audio_flag_oe !== 1'h1; i++) @(posedge aclk);
    repeat (2) @(posedge aclk);
    `CHK("audio", 1'h1, audio_flag_oe)
    `CHK("audio vbus", 1'h0, vbus_switch_on)
    `CHK("audio debug", 1'h0, debug_flag_oe)
    over_temp <= 1'h1;
    repeat (8) @(posedge aclk);
    `CHK("over temp", 1'h1, fault_flag_oe)
    over_temp <= 1'h0;
    enable_pin <= 1'h0;
    repeat (8) @(posedge aclk);
    `CHK("off audio", 1'h0, audio_flag_oe)
    `CHK("off advertise", 2'(adv_default), cc1_advertise)
    $display("test accessory done");
    results();
  end
endmodule
`default_nettype wire
